// ===== hw/tlb_map.vh
`ifndef TLB_MAP_VH
`define TLB_MAP_VH
// ************************************************************
// geometry
// ************************************************************
`define ENT_N        8
`define IDX_W        3
`define VPN_W        19
`define MASK_W       16
`define ADDRESS_SPACE_TAG_W       8
`define PFN_W        20
`define LO_W         25
// ************************************************************
// register word offsets, haddr[4:2]
// ************************************************************
`define OFS_EHI      3'h0
`define OFS_ELO0     3'h1
`define OFS_ELO1     3'h2
`define OFS_PMASK    3'h3
`define OFS_INDEX    3'h4
`define OFS_CFG      3'h5
`define OFS_CMD      3'h6
`define OFS_STAT     3'h7
// ************************************************************
// field positions
// ************************************************************
`define EHI_VPN_HI   31
`define EHI_VPN_LO   13
`define EHI_INV_BIT  10
`define EHI_ADDRESS_SPACE_TAG_HI  7
`define LO_PFN_HI    25
`define LO_G_BIT     0
`define PM_MASK_HI   28
`define PM_MASK_LO   13
`define IDX_MISS_BIT 31
`define CFG_COP_BIT  0
`define CFG_TYPE_HI  3
`define CFG_TYPE_LO  1
`define CFG_CAP_HI   5
`define CFG_CAP_LO   4
`define CFG_REL_HI   8
`define CFG_REL_LO   6
`define CFG_ZM_BIT   9
`define CFG_MC_BIT   10
`define ST_CPU_BIT   0
`define ST_RI_BIT    1
`define ST_MC_BIT    2
`define ST_DONE_BIT  3
// ************************************************************
// commands, type codes and reset values
// ************************************************************
`define CMD_PROBE    2'h1
`define CMD_READ     2'h2
`define CMD_WRITE    2'h3
`define TYPE_BLOCK   3'h2
`define TYPE_FIXED   3'h3
`define REL_MC_PROBE 3'h3
`define REL_SIX      3'h6
`define CFG_RST      32'h00000593
`define MIN_PAGE     16'h0000
`endif

// ===== hw/tlb_entry_store.v
`timescale 1ns/1ps
`include "tlb_map.vh"
module tlb_entry_store (
   // clock and reset
   input  wire                         core_clk_in,
   input  wire                         rst_n_in,
   // write port
   input  wire                         wr_en_in,
   input  wire                         inv_en_in,
   input  wire [`IDX_W-1:0]            idx_in,
   input  wire [`VPN_W-1:0]            vpn_in,
   input  wire [`MASK_W-1:0]           mask_in,
   input  wire [`ADDRESS_SPACE_TAG_W-1:0]           address_space_tag_in,
   input  wire                         g_in,
   input  wire [`LO_W-1:0]             lo0_in,
   input  wire [`LO_W-1:0]             lo1_in,
   // flattened contents
   output wire [`ENT_N*`VPN_W-1:0]     vpn_out,
   output wire [`ENT_N*`MASK_W-1:0]    mask_out,
   output wire [`ENT_N*`ADDRESS_SPACE_TAG_W-1:0]    address_space_tag_out,
   output wire [`ENT_N-1:0]            g_out,
   output wire [`ENT_N-1:0]            inv_out,
   output wire [`ENT_N*`LO_W-1:0]      lo0_out,
   output wire [`ENT_N*`LO_W-1:0]      lo1_out
);
   reg [`VPN_W-1:0]  vpn_q  [0:`ENT_N-1];
   reg [`MASK_W-1:0] mask_q [0:`ENT_N-1];
   reg [`ADDRESS_SPACE_TAG_W-1:0] address_space_tag_q [0:`ENT_N-1];
   reg [`LO_W-1:0]   lo0_q  [0:`ENT_N-1];
   reg [`LO_W-1:0]   lo1_q  [0:`ENT_N-1];
   reg [`ENT_N-1:0]  g_q;
   reg [`ENT_N-1:0]  inv_q;
   integer           i;

   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         g_q   <= {`ENT_N{1'b0}};
         inv_q <= {`ENT_N{1'b1}};
         for (i = 0; i < `ENT_N; i = i + 1) begin
            vpn_q[i]  <= {`VPN_W{1'b0}};
            mask_q[i] <= {`MASK_W{1'b0}};
            address_space_tag_q[i] <= {`ADDRESS_SPACE_TAG_W{1'b0}};
            lo0_q[i]  <= {`LO_W{1'b0}};
            lo1_q[i]  <= {`LO_W{1'b0}};
         end
      end else if (inv_en_in) begin
         inv_q[idx_in] <= 1'b1;
      end else if (wr_en_in) begin
         inv_q[idx_in]  <= 1'b0;
         vpn_q[idx_in]  <= vpn_in;
         mask_q[idx_in] <= mask_in;
         address_space_tag_q[idx_in] <= address_space_tag_in;
         g_q[idx_in]    <= g_in;
         lo0_q[idx_in]  <= lo0_in;
         lo1_q[idx_in]  <= lo1_in;
      end
   end

   genvar k;
   generate
      for (k = 0; k < `ENT_N; k = k + 1) begin : flat
         assign vpn_out[k*`VPN_W +: `VPN_W]    = vpn_q[k];
         assign mask_out[k*`MASK_W +: `MASK_W] = mask_q[k];
         assign address_space_tag_out[k*`ADDRESS_SPACE_TAG_W +: `ADDRESS_SPACE_TAG_W] = address_space_tag_q[k];
         assign lo0_out[k*`LO_W +: `LO_W]      = lo0_q[k];
         assign lo1_out[k*`LO_W +: `LO_W]      = lo1_q[k];
      end
   endgenerate
   assign g_out   = g_q;
   assign inv_out = inv_q;
endmodule // tlb_entry_store

// ===== hw/tlb_probe_match.v
`timescale 1ns/1ps
`include "tlb_map.vh"
module tlb_probe_match (
   // stored entries
   input  wire [`ENT_N*`VPN_W-1:0]     vpn_in,
   input  wire [`ENT_N*`MASK_W-1:0]    mask_in,
   input  wire [`ENT_N*`ADDRESS_SPACE_TAG_W-1:0]    address_space_tag_in,
   input  wire [`ENT_N-1:0]            g_in,
   input  wire [`ENT_N-1:0]            inv_in,
   // search key
   input  wire [`VPN_W-1:0]            key_vpn_in,
   input  wire [`ADDRESS_SPACE_TAG_W-1:0]           key_address_space_tag_in,
   // result
   output reg  [`ENT_N-1:0]            hit_out
);
   reg [`VPN_W-1:0] m;
   integer          i;

   // page-size mask bits ignored, global entries match any tag
   always @* begin
      m       = {`VPN_W{1'b0}};
      hit_out = {`ENT_N{1'b0}};
      for (i = 0; i < `ENT_N; i = i + 1) begin
         m = ~{3'h0, mask_in[i*`MASK_W +: `MASK_W]};
         hit_out[i] = !inv_in[i] &&
            ((vpn_in[i*`VPN_W +: `VPN_W] & m) == (key_vpn_in & m)) &&
            (g_in[i] ||
             address_space_tag_in[i*`ADDRESS_SPACE_TAG_W +: `ADDRESS_SPACE_TAG_W] == key_address_space_tag_in);
      end
   end
endmodule // tlb_probe_match

// ===== hw/tlb_maint.v
`timescale 1ns/1ps
`include "tlb_map.vh"
module tlb_maint (
   // clock and reset
   input  wire                core_clk_in,
   input  wire                rst_n_in,
   // ahb-lite slave
   input  wire                hsel_in,
   input  wire [31:0]         haddr_in,
   input  wire [1:0]          htrans_in,
   input  wire                hwrite_in,
   input  wire [2:0]          hsize_in,
   input  wire [31:0]         hwdata_in,
   input  wire                hready_in,
   output reg                 hreadyout_out,
   output reg  [31:0]         hrdata_out,
   output reg                 hresp_out,
   // exception and completion pulses to the pipeline
   output reg                 op_done_out,
   output reg                 cop_unusable_out,
   output reg                 reserved_instr_out,
   output reg                 machine_check_out
);
   // ************************************************************
   // helpers
   // ************************************************************
   function [`PFN_W-1:0] cut_mask;
      input [`PFN_W-1:0]  val;
      input [`MASK_W-1:0] mask;
      input               en;
      begin
         cut_mask = en ? (val & ~{4'h0, mask}) : val;
      end
   endfunction

   function multi_hit;
      input [`ENT_N-1:0] v;
      begin
         multi_hit = (v & (v - {{(`ENT_N-1){1'b0}}, 1'b1})) !=
                     {`ENT_N{1'b0}};
      end
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   reg [`VPN_W-1:0]   ehi_vpn_q;
   reg                ehi_inv_q;
   reg [`ADDRESS_SPACE_TAG_W-1:0]  ehi_address_space_tag_q;
   reg [`LO_W:0]      elo0_q;
   reg [`LO_W:0]      elo1_q;
   reg [`MASK_W-1:0]  pmask_q;
   reg [`IDX_W-1:0]   index_q;
   reg                index_miss_q;
   reg [31:0]         cfg_q;
   reg [3:0]          stat_q;
   reg                ap_valid_q;
   reg                ap_write_q;
   reg [2:0]          ap_addr_q;

   reg [`VPN_W-1:0]   ehi_vpn_d;
   reg                ehi_inv_d;
   reg [`ADDRESS_SPACE_TAG_W-1:0]  ehi_address_space_tag_d;
   reg [`LO_W:0]      elo0_d;
   reg [`LO_W:0]      elo1_d;
   reg [`MASK_W-1:0]  pmask_d;
   reg [`IDX_W-1:0]   index_d;
   reg                index_miss_d;
   reg [31:0]         cfg_d;
   reg [3:0]          stat_d;
   reg [3:0]          ev_set;
   reg                st_wr;
   reg                st_inv;
   reg [31:0]         rd_mux;
   reg [`IDX_W-1:0]   hit_idx;
   integer            i;

   wire [`ENT_N*`VPN_W-1:0]  e_vpn;
   wire [`ENT_N*`MASK_W-1:0] e_mask;
   wire [`ENT_N*`ADDRESS_SPACE_TAG_W-1:0] e_address_space_tag;
   wire [`ENT_N-1:0]         e_g;
   wire [`ENT_N-1:0]         e_inv;
   wire [`ENT_N*`LO_W-1:0]   e_lo0;
   wire [`ENT_N*`LO_W-1:0]   e_lo1;
   wire [`ENT_N-1:0]         hit_vec;

   // ************************************************************
   // configuration fields
   // ************************************************************
   wire       cop_en                = cfg_q[`CFG_COP_BIT];
   wire [2:0] mmu_type_field        = cfg_q[`CFG_TYPE_HI:`CFG_TYPE_LO];
   wire [1:0] invalidate_capability = cfg_q[`CFG_CAP_HI:`CFG_CAP_LO];
   wire [2:0] rel                   = cfg_q[`CFG_REL_HI:`CFG_REL_LO];
   wire       zm                    = cfg_q[`CFG_ZM_BIT];
   wire       mc_det                = cfg_q[`CFG_MC_BIT];
   wire       cap_on                = invalidate_capability != 2'h0;

   // ************************************************************
   // bus decode
   // ************************************************************
   wire accept  = hsel_in && hready_in && htrans_in[1];
   wire wr_en   = ap_valid_q && ap_write_q && hreadyout_out;
   wire rd_load = ap_valid_q && !ap_write_q && !hreadyout_out;
   wire cmd_wr  = wr_en && ap_addr_q == `OFS_CMD;
   wire [1:0] cmd = hwdata_in[1:0];

   // ************************************************************
   // selected entry
   // ************************************************************
   wire [`VPN_W-1:0]  s_vpn  = e_vpn[index_q*`VPN_W +: `VPN_W];
   wire [`MASK_W-1:0] s_mask = e_mask[index_q*`MASK_W +: `MASK_W];
   wire [`ADDRESS_SPACE_TAG_W-1:0] s_address_space_tag = e_address_space_tag[index_q*`ADDRESS_SPACE_TAG_W +: `ADDRESS_SPACE_TAG_W];
   wire [`LO_W-1:0]   s_lo0  = e_lo0[index_q*`LO_W +: `LO_W];
   wire [`LO_W-1:0]   s_lo1  = e_lo1[index_q*`LO_W +: `LO_W];
   wire               s_g    = e_g[index_q];
   wire               s_inv  = e_inv[index_q];

   // ************************************************************
   // exception qualification
   // ************************************************************
   wire is_cpu = cmd_wr && cmd != 2'h0 && !cop_en;
   wire is_ri  = cmd_wr && cmd != 2'h0 && cop_en && rel == `REL_SIX &&
                 (mmu_type_field == `TYPE_BLOCK ||
                  mmu_type_field == `TYPE_FIXED);
   wire go     = cmd_wr && cop_en && !is_ri;
   wire do_prb = go && cmd == `CMD_PROBE;
   wire do_rd  = go && cmd == `CMD_READ;
   wire do_wr  = go && cmd == `CMD_WRITE;
   wire wr_inv = do_wr && cap_on && ehi_inv_q;
   // other entries already hit by the new key
   wire [`ENT_N-1:0] others =
      hit_vec & ~({{(`ENT_N-1){1'b0}}, 1'b1} << index_q);

   // ************************************************************
   // entry storage and matcher
   // ************************************************************
   wire [`PFN_W-1:0] w_vpn  = cut_mask({1'b0, ehi_vpn_q}, pmask_q, zm);
   wire [`PFN_W-1:0] w_pfn0 = cut_mask(elo0_q[`LO_PFN_HI:6], pmask_q, zm);
   wire [`PFN_W-1:0] w_pfn1 = cut_mask(elo1_q[`LO_PFN_HI:6], pmask_q, zm);
   wire [`PFN_W-1:0] r_vpn  = cut_mask({1'b0, s_vpn}, s_mask, zm);
   wire [`PFN_W-1:0] r_pfn0 = cut_mask(s_lo0[`LO_W-1:5], s_mask, zm);
   wire [`PFN_W-1:0] r_pfn1 = cut_mask(s_lo1[`LO_W-1:5], s_mask, zm);

   tlb_entry_store u_store (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .wr_en_in    (st_wr),
      .inv_en_in   (st_inv),
      .idx_in      (index_q),
      .vpn_in      (w_vpn[`VPN_W-1:0]),
      .mask_in     (pmask_q),
      .address_space_tag_in     (ehi_address_space_tag_q),
      .g_in        (elo0_q[`LO_G_BIT] & elo1_q[`LO_G_BIT]),
      .lo0_in      ({w_pfn0, elo0_q[5:1]}),
      .lo1_in      ({w_pfn1, elo1_q[5:1]}),
      .vpn_out     (e_vpn),
      .mask_out    (e_mask),
      .address_space_tag_out    (e_address_space_tag),
      .g_out       (e_g),
      .inv_out     (e_inv),
      .lo0_out     (e_lo0),
      .lo1_out     (e_lo1)
   );

   tlb_probe_match u_match (
      .vpn_in      (e_vpn),
      .mask_in     (e_mask),
      .address_space_tag_in     (e_address_space_tag),
      .g_in        (e_g),
      .inv_in      (e_inv),
      .key_vpn_in  (ehi_vpn_q),
      .key_address_space_tag_in (ehi_address_space_tag_q),
      .hit_out     (hit_vec)
   );

   always @* begin
      hit_idx = {`IDX_W{1'b0}};
      for (i = 0; i < `ENT_N; i = i + 1) begin
         if (hit_vec[i]) begin
            hit_idx = i[`IDX_W-1:0];
         end
      end
   end

   // ************************************************************
   // operation and register update
   // ************************************************************
   always @* begin
      ehi_vpn_d    = ehi_vpn_q;
      ehi_inv_d    = ehi_inv_q;
      ehi_address_space_tag_d   = ehi_address_space_tag_q;
      elo0_d       = elo0_q;
      elo1_d       = elo1_q;
      pmask_d      = pmask_q;
      index_d      = index_q;
      index_miss_d = index_miss_q;
      cfg_d        = cfg_q;
      ev_set       = 4'h0;
      st_wr        = 1'b0;
      st_inv       = 1'b0;
      if (wr_en) begin
         case (ap_addr_q)
            `OFS_EHI: begin
               ehi_vpn_d  = hwdata_in[`EHI_VPN_HI:`EHI_VPN_LO];
               ehi_inv_d  = hwdata_in[`EHI_INV_BIT];
               ehi_address_space_tag_d = hwdata_in[`EHI_ADDRESS_SPACE_TAG_HI:0];
            end
            `OFS_ELO0:  elo0_d  = hwdata_in[`LO_W:0];
            `OFS_ELO1:  elo1_d  = hwdata_in[`LO_W:0];
            `OFS_PMASK: pmask_d = hwdata_in[`PM_MASK_HI:`PM_MASK_LO];
            `OFS_INDEX: begin
               index_d      = hwdata_in[`IDX_W-1:0];
               index_miss_d = 1'b0;
            end
            `OFS_CFG:   cfg_d   = hwdata_in;
            default: ;
         endcase
      end
      ev_set[`ST_CPU_BIT] = is_cpu;
      ev_set[`ST_RI_BIT]  = is_ri;
      ev_set[`ST_DONE_BIT] = go && cmd != 2'h0;
      if (do_prb) begin
         index_d      = hit_idx;
         index_miss_d = hit_vec == {`ENT_N{1'b0}};
         // probe multi-match only from release three on
         ev_set[`ST_MC_BIT] = mc_det && rel >= `REL_MC_PROBE &&
                              multi_hit(hit_vec);
      end
      // reads never report multi-match
      if (do_rd) begin
         if (cap_on && s_inv) begin
            ehi_vpn_d  = {`VPN_W{1'b0}};
            ehi_inv_d  = 1'b1;
            ehi_address_space_tag_d = {`ADDRESS_SPACE_TAG_W{1'b0}};
            elo0_d     = {(`LO_W+1){1'b0}};
            elo1_d     = {(`LO_W+1){1'b0}};
            pmask_d    = `MIN_PAGE;
         end else begin
            ehi_vpn_d  = r_vpn[`VPN_W-1:0];
            ehi_inv_d  = 1'b0;
            ehi_address_space_tag_d = s_address_space_tag;
            pmask_d    = s_mask;
            elo0_d     = {r_pfn0, s_lo0[4:0], s_g};
            elo1_d     = {r_pfn1, s_lo1[4:0], s_g};
         end
      end
      if (wr_inv) begin
         st_inv = 1'b1;
      end else if (do_wr) begin
         st_wr = 1'b1;
         // invalid marker cleared by the store
         ev_set[`ST_MC_BIT] = mc_det &&
            others != {`ENT_N{1'b0}};
      end
      // invalidating writes set only the done bit of ev_set
      // set wins over write-one-to-clear
      stat_d = stat_q;
      if (wr_en && ap_addr_q == `OFS_STAT) begin
         stat_d = stat_q & ~hwdata_in[3:0];
      end
      stat_d = stat_d | ev_set;
   end

   // ************************************************************
   // read mux
   // ************************************************************
   always @* begin
      case (ap_addr_q)
         `OFS_EHI:   rd_mux = {ehi_vpn_q, 2'h0, ehi_inv_q, 2'h0,
                               ehi_address_space_tag_q};
         `OFS_ELO0:  rd_mux = {6'h00, elo0_q};
         `OFS_ELO1:  rd_mux = {6'h00, elo1_q};
         `OFS_PMASK: rd_mux = {3'h0, pmask_q, 13'h0000};
         `OFS_INDEX: rd_mux = {index_miss_q, 28'h0000000, index_q};
         `OFS_CFG:   rd_mux = cfg_q;
         `OFS_STAT:  rd_mux = {28'h0000000, stat_q};
         default:    rd_mux = 32'h00000000;
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ehi_vpn_q          <= {`VPN_W{1'b0}};
         ehi_inv_q          <= 1'b0;
         ehi_address_space_tag_q         <= {`ADDRESS_SPACE_TAG_W{1'b0}};
         elo0_q             <= {(`LO_W+1){1'b0}};
         elo1_q             <= {(`LO_W+1){1'b0}};
         pmask_q            <= `MIN_PAGE;
         index_q            <= {`IDX_W{1'b0}};
         index_miss_q       <= 1'b0;
         cfg_q              <= `CFG_RST;
         stat_q             <= 4'h0;
         ap_valid_q         <= 1'b0;
         ap_write_q         <= 1'b0;
         ap_addr_q          <= 3'h0;
         hreadyout_out      <= 1'b1;
         hrdata_out         <= 32'h00000000;
         hresp_out          <= 1'b0;
         op_done_out        <= 1'b0;
         cop_unusable_out   <= 1'b0;
         reserved_instr_out <= 1'b0;
         machine_check_out  <= 1'b0;
      end else begin
         ehi_vpn_q          <= ehi_vpn_d;
         ehi_inv_q          <= ehi_inv_d;
         ehi_address_space_tag_q         <= ehi_address_space_tag_d;
         elo0_q             <= elo0_d;
         elo1_q             <= elo1_d;
         pmask_q            <= pmask_d;
         index_q            <= index_d;
         index_miss_q       <= index_miss_d;
         cfg_q              <= cfg_d;
         stat_q             <= stat_d;
         if (accept) begin
            ap_valid_q <= 1'b1;
            ap_write_q <= hwrite_in;
            ap_addr_q  <= haddr_in[4:2];
         end else if (hreadyout_out) begin
            ap_valid_q <= 1'b0;
         end
         // reads take one wait state so ops land first
         hreadyout_out <= !(accept && !hwrite_in);
         if (rd_load) begin
            hrdata_out <= rd_mux;
         end
         hresp_out          <= 1'b0;
         op_done_out        <= ev_set[`ST_DONE_BIT];
         cop_unusable_out   <= ev_set[`ST_CPU_BIT];
         reserved_instr_out <= ev_set[`ST_RI_BIT];
         machine_check_out  <= ev_set[`ST_MC_BIT];
      end
   end
endmodule // tlb_maint

// ===== tb/tlb_pipe_model.sv
`timescale 1ns/1ps
// ********************
// pipeline exception taker
// ********************
module tlb_pipe_model (
   // clock and reset
   input  wire       core_clk_in,
   input  wire       rst_n_in,
   // pulses from the block
   input  wire       op_done_in,
   input  wire       cop_unusable_in,
   input  wire       reserved_instr_in,
   input  wire       machine_check_in,
   // bench control
   input  wire       clr_in,
   output reg  [3:0] taken_out
);
   // sticky, same bit order as the status register
   always @(posedge core_clk_in) begin
      if (!rst_n_in || clr_in) begin
         taken_out <= 4'h0;
      end else begin
         taken_out <= taken_out | {op_done_in, machine_check_in,
                                   reserved_instr_in, cop_unusable_in};
      end
   end
endmodule // tlb_pipe_model

// ===== tb/tlb_maint_assertions.sv
`timescale 1ns/1ps
module tlb_maint_chk (
   input wire        core_clk_in,
   input wire        rst_n_in,
   input wire        hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0]  htrans_in,
   input wire        hwrite_in,
   input wire [2:0]  hsize_in,
   input wire [31:0] hwdata_in,
   input wire        hready_in,
   input wire        hreadyout_out,
   input wire [31:0] hrdata_out,
   input wire        hresp_out,
   input wire        op_done_out,
   input wire        cop_unusable_out,
   input wire        reserved_instr_out,
   input wire        machine_check_out
);
   wire taken = hsel_in && hready_in && htrans_in[1];
   reg  cmd_dph_q;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // ********************
   // command data phase tracker
   // ********************
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cmd_dph_q <= 1'b0;
      end else begin
         cmd_dph_q <= taken && hwrite_in && (haddr_in[4:2] == 3'h6);
      end
   end
   chk_resp_okay: assert property (hresp_out == 1'b0)
      else $error("bus response not okay");
   chk_read_stall: assert property (taken && !hwrite_in |=>
      !hreadyout_out ##1 hreadyout_out) else $error("read wait wrong");
   chk_write_ready: assert property (taken && hwrite_in |=> hreadyout_out)
      else $error("write wait state");
   chk_rdata_hold: assert property (!$stable(hrdata_out) |->
      $past(hreadyout_out) == 1'b0) else $error("read data moved");
   chk_pulse_cause: assert property (
      op_done_out || cop_unusable_out || reserved_instr_out |->
      $past(cmd_dph_q)) else $error("pulse without command");
   chk_cop_first: assert property (
      cop_unusable_out |-> !reserved_instr_out && !op_done_out &&
      !machine_check_out) else $error("unusable op went on");
   chk_ri_blocks: assert property (
      reserved_instr_out |-> !op_done_out && !machine_check_out)
      else $error("reserved op went on");
   chk_mc_executed: assert property (
      machine_check_out |-> op_done_out) else $error("check without op");
endmodule // tlb_maint_chk
bind tlb_maint tlb_maint_chk i_chk (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
   .hwdata_in(hwdata_in), .hready_in(hready_in),
   .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
   .hresp_out(hresp_out), .op_done_out(op_done_out),
   .cop_unusable_out(cop_unusable_out),
   .reserved_instr_out(reserved_instr_out),
   .machine_check_out(machine_check_out));

// ===== tb/tlb_maint_tb_top.sv
`timescale 1ns/1ps
module tlb_maint_tb_top;
   localparam [31:0] EHI_A = 32'h2468A005;
   localparam [31:0] LO0   = 32'h00001247;
   localparam [31:0] LO1   = 32'h00003456;
   localparam [31:0] PM    = 32'h00006000;
   reg         core_clk_in, rst_n_in, hsel, hwrite, clr;
   reg  [31:0] haddr, hwdata, rd;
   reg  [1:0]  htrans;
   wire        hready, done, cop, ri, mc;
   wire [31:0] hrdata;
   wire [3:0]  taken;
   integer     errors, n_compared, cycles, r;
   always #50 core_clk_in = ~core_clk_in;
   tlb_maint i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
      .hresp_out(), .op_done_out(done), .cop_unusable_out(cop),
      .reserved_instr_out(ri), .machine_check_out(mc));
   tlb_pipe_model i_pipe (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .op_done_in(done), .cop_unusable_in(cop), .reserved_instr_in(ri),
      .machine_check_in(mc), .clr_in(clr), .taken_out(taken));
   // ********************
   // compare and bus tasks
   // ********************
   task final_report;
      begin
         if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   task chk_word(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task chk_flags(input [3:0] got, input [3:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task bus(input w, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
         @(posedge core_clk_in);
         while (hready !== 1'b1) @(posedge core_clk_in);
         hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
         @(posedge core_clk_in);
         while (hready !== 1'b1) @(posedge core_clk_in);
         rd = hrdata;
      end
   endtask
   task chk_rd(input [31:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h0);
         chk_word(rd, exp);
      end
   endtask
   // index kept below entry count
   task load(input [31:0] e, l0, l1, p, input [2:0] idx);
      begin
         bus(1'b1, 32'h00, e); bus(1'b1, 32'h04, l0);
         bus(1'b1, 32'h08, l1); bus(1'b1, 32'h0C, p);
         bus(1'b1, 32'h10, {29'h0, idx});
      end
   endtask
   task do_op(input [1:0] cmd, input [3:0] exp);
      begin
         bus(1'b1, 32'h18, {30'h0, cmd});
         repeat (2) @(posedge core_clk_in);
         chk_flags(taken, exp);
         chk_rd(32'h1C, {28'h0, exp});
         clr <= 1'b1;
         bus(1'b1, 32'h1C, 32'h0000000F);
         clr <= 1'b0;
      end
   endtask
   task chk_stage(input [31:0] e, l0, l1, p);
      begin
         chk_rd(32'h00, e); chk_rd(32'h04, l0);
         chk_rd(32'h08, l1); chk_rd(32'h0C, p);
      end
   endtask
   always @(posedge core_clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         final_report;
      end
   end
   // ********************
   // main sequence
   // ********************
   initial begin
      core_clk_in = 1'b0; rst_n_in = 1'b0; hsel = 1'b0; hwrite = 1'b0;
      clr = 1'b0; haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0;
      errors = 0; n_compared = 0; cycles = 0;
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      chk_rd(32'h14, 32'h00000593);
      load(EHI_A, LO0, LO1, PM, 3'h2);
      do_op(2'h3, 4'h8);
      bus(1'b1, 32'h00, EHI_A ^ 32'h00006000);
      do_op(2'h1, 4'h8);
      chk_rd(32'h10, 32'h00000002);
      bus(1'b1, 32'h00, EHI_A + 32'h1);
      do_op(2'h1, 4'h8);
      chk_rd(32'h10, 32'h80000000);
      load(32'h13570009, 32'h1, 32'h1, 32'h0, 3'h3);
      do_op(2'h3, 4'h8);
      bus(1'b1, 32'h00, 32'h135700AA);
      do_op(2'h1, 4'h8);
      chk_rd(32'h10, 32'h00000003);
      load(32'h0, 32'h0, 32'h0, 32'h0, 3'h2);
      do_op(2'h2, 4'h8);
      chk_stage(EHI_A, 32'h00001246, LO1, PM);
      load(EHI_A, LO0, LO1, PM, 3'h4);
      do_op(2'h3, 4'hC);
      do_op(2'h1, 4'hC);
      chk_rd(32'h10, 32'h00000004);
      load(EHI_A | 32'h00000400, 32'h0, 32'h0, 32'h0, 3'h4);
      do_op(2'h3, 4'h8);
      do_op(2'h2, 4'h8);
      chk_stage(32'h00000400, 32'h0, 32'h0, 32'h0);
      bus(1'b1, 32'h00, EHI_A);
      do_op(2'h1, 4'h8);
      chk_rd(32'h10, 32'h00000002);
      load(EHI_A, LO0, LO1, PM, 3'h4);
      do_op(2'h3, 4'hC);
      do_op(2'h2, 4'h8);
      chk_stage(EHI_A, 32'h00001246, LO1, PM);
      for (r = 1; r <= 2; r = r + 1) begin
         bus(1'b1, 32'h14, 32'h00000413 | (r << 6));
         bus(1'b1, 32'h00, EHI_A);
         do_op(2'h1, 4'h8);
         load(EHI_A, LO0, LO1, PM, 3'h5);
         do_op(2'h3, 4'hC);
      end
      bus(1'b1, 32'h14, 32'h00000793);
      load(32'h0, 32'h0, 32'h0, 32'h0, 3'h5);
      do_op(2'h2, 4'h8);
      chk_stage(32'h24688005, 32'h00001206, 32'h00003416, PM);
      bus(1'b1, 32'h14, 32'h00000783);
      load(EHI_A | 32'h00000400, LO0, LO1, PM, 3'h6);
      do_op(2'h3, 4'hC);
      bus(1'b1, 32'h14, 32'h00000583);
      do_op(2'h2, 4'h8);
      chk_stage(32'h24688005, 32'h00001206, 32'h00003416, PM);
      for (r = 2; r <= 3; r = r + 1) begin
         bus(1'b1, 32'h14, 32'h00000591 | (r << 1));
         bus(1'b1, 32'h10, 32'h00000007);
         do_op(2'h1, 4'h2);
         chk_rd(32'h10, 32'h00000007);
      end
      bus(1'b1, 32'h14, 32'h00000594);
      do_op(2'h1, 4'h1);
      chk_rd(32'h10, 32'h00000007);
      final_report;
   end
endmodule // tlb_maint_tb_top
